// ===== include/vxl_params.svh
// Constants for the display controller extension register bank.
// Assumes an ISA-style host bus sampled on the host clock.
`ifndef VXL_PARAMS_SVH
`define VXL_PARAMS_SVH

// ----------------------------------------
// I/O port addresses
// ----------------------------------------
`define VXL_PORT_SEQ_IDX 16'h03C4
`define VXL_PORT_SEQ_DAT 16'h03C5
`define VXL_PORT_GFX_IDX 16'h03CE
`define VXL_PORT_GFX_DAT 16'h03CF
`define VXL_PORT_MISC_WR 16'h03C2
`define VXL_PORT_MISC_RD 16'h03CC
`define VXL_PORT_CRT_IDX_M 16'h03B4
`define VXL_PORT_CRT_DAT_M 16'h03B5
`define VXL_PORT_CRT_IDX_C 16'h03D4
`define VXL_PORT_CRT_DAT_C 16'h03D5

// ----------------------------------------
// Register indices
// ----------------------------------------
`define VXL_IDX_MEM_IF 8'h0B
`define VXL_IDX_VID_SEL 8'h0C
`define VXL_IDX_TLOCK 8'h0D
`define VXL_IDX_MB_WIN 8'h14
`define VXL_IDX_EXT_CTL 8'h15
`define VXL_IDX_CW_CTL 8'h17
`define VXL_IDX_CRT_LAST 8'h17

// ----------------------------------------
// Field positions
// ----------------------------------------
`define VXL_MIF_ROM_OUT 0
`define VXL_MIF_CS16 2
`define VXL_MIF_ALT_OFS 3
`define VXL_EXT_PAGE 2
`define VXL_CW_TEN 5
`define VXL_CRT_PROT 7

// ----------------------------------------
// Reset values
// ----------------------------------------
`define VXL_RST_BYTE 8'h00

`endif

// ===== include/vxl_pkg.sv
// Types shared by the extension register bank.
// Assumes nothing beyond the parameter header.
`default_nettype none
package vxl_pkg;
  typedef enum logic [1:0] {VXL_MAP_VGA, VXL_MAP_256K, VXL_MAP_512K, VXL_MAP_1M} vxl_map_t;
endpackage
`default_nettype wire

// ===== hdl/vxl_regs.sv
// Extension registers, CRTC register file with group locking, and decode.
// Assumes one-cycle host I/O strobes synchronous to i_clk.
`include "vxl_params.svh"
`default_nettype none

// How it works
// - Map field picks CPU decode window
// - Window register picks the megabyte
// - Bit 2 drives 16-bit chip select low
// - ROM map-out, loaded inverted from strap
// - Bit 6 selects legacy CRT mode
// - Map bits and attribute pick plane
// - Page mode overrides plane selection
// - Width field sets text character dots
// - Graphics modes always use eight dots
// - Underline odd attributes, background bit zero
// - Force full video clock for horizontal
// - Lock sync polarity bits of misc
// - Horizontal lock covers groups zero, four
// - Lock bits extend start and cursor
// - Double cursor and scan line values
// - Lock prevention keeps group one open
// - Vertical lock covers groups two, three
// - Protect bit guards CRTC zero to seven
// - Group zero: indices 00 through 05
// - Group one: index 07 bits 1,6
// - Group two: vertical overflow fields
// - Group three: indices 10,11,15,16
// - Group four: index 17 bit 2
module vxl_regs #(
  parameter int CRT_REGS = 24
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [15:0] i_io_addr,
  input wire logic i_io_wr,
  input wire logic i_io_rd,
  input wire logic [7:0] i_io_wdata,
  output logic [7:0] o_io_rdata,
  input wire logic [23:0] i_mem_addr,
  input wire logic i_mem_cycle,
  input wire logic i_strap_bit0,
  input wire logic [7:0] i_attr_code,
  input wire logic i_graphics_mode,
  input wire logic i_nine_dot,
  input wire logic i_seq_half_clk,
  output logic o_mem_hit,
  output logic o_memcs16_n,
  output logic o_rom_unmap,
  output logic o_alt_offset_en,
  output logic o_legacy_crt,
  output logic o_char_plane3,
  output logic o_page_mode,
  output logic [3:0] o_char_dots,
  output logic o_underline,
  output logic [7:0] o_attr_eff,
  output logic o_hclk_half,
  output logic [1:0] o_sync_pol,
  output logic [17:0] o_start_addr,
  output logic [17:0] o_cursor_addr,
  output logic [5:0] o_cursor_start,
  output logic [5:0] o_cursor_stop,
  output logic [5:0] o_preset_row,
  output logic [5:0] o_max_scan,
  output logic [4:0] o_group_locked
);

  if (CRT_REGS != 24)
  begin : g_bad_crt_regs
    $error("CRT_REGS must be 24");
  end

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic [7:0] gfx_idx_r, seq_idx_r, crt_idx_r;
  logic [7:0] mem_if_r, vid_sel_r, tlock_r, mb_win_r, ext_ctl_r, cw_ctl_r, misc_r;
  logic [7:0] crt_r [0:CRT_REGS-1];
  logic strap_s1_r, strap_s2_r, strap_done_r;
  logic strap_v1_r, strap_v2_r;

  // ----------------------------------------
  // Lock decode
  // ----------------------------------------
  wire prot = crt_r[17][`VXL_CRT_PROT];
  wire lk_g0 = tlock_r[5] | prot;
  wire lk_g1 = ~tlock_r[1] & prot;
  wire lk_g2 = tlock_r[0] | prot;
  wire lk_g3 = tlock_r[0];
  wire lk_g4 = tlock_r[5];
  wire [4:0] lk_all = {lk_g4, lk_g3, lk_g2, lk_g1, lk_g0};

  // Writable bits of a CRTC index; locks come in as an argument so the
  // mask follows a lock change even when the index stays put
  function automatic logic [7:0] crt_wmask(input logic [7:0] idx, input logic [4:0] lk);
    logic [7:0] m;
    m = 8'hFF;
    if (idx <= 8'h05)
      m = lk[0] ? 8'h00 : 8'hFF;
    else if (idx == 8'h06)
      m = lk[2] ? 8'h00 : 8'hFF;
    else if (idx == 8'h07)
      m = {~lk[2], ~lk[1], ~lk[2], 1'b1, ~lk[2], ~lk[2], ~lk[1], ~lk[2]};
    else if (idx == 8'h09)
      m = lk[2] ? 8'hDF : 8'hFF;
    else if (idx == 8'h10 || idx == 8'h15 || idx == 8'h16)
      m = lk[3] ? 8'h00 : 8'hFF;
    else if (idx == 8'h11)
      m = lk[3] ? 8'hF0 : 8'hFF;
    else if (idx == 8'h17)
      m = lk[4] ? 8'hFB : 8'hFF;
    return m;
  endfunction

  // ----------------------------------------
  // Port decode
  // ----------------------------------------
  wire crt_idx_port = i_io_addr == `VXL_PORT_CRT_IDX_M || i_io_addr == `VXL_PORT_CRT_IDX_C;
  wire crt_dat_port = i_io_addr == `VXL_PORT_CRT_DAT_M || i_io_addr == `VXL_PORT_CRT_DAT_C;
  wire gfx_dat_wr = i_io_wr && i_io_addr == `VXL_PORT_GFX_DAT;
  wire seq_dat_wr = i_io_wr && i_io_addr == `VXL_PORT_SEQ_DAT;
  wire crt_dat_wr = i_io_wr && crt_dat_port && crt_idx_r <= `VXL_IDX_CRT_LAST;
  wire [7:0] crt_mask = crt_wmask(crt_idx_r, lk_all);
  wire [7:0] crt_cur = crt_r[crt_idx_r[4:0]];
  wire [7:0] crt_new = (crt_cur & ~crt_mask) | (i_io_wdata & crt_mask);
  // Sync polarity bits keep their value while locked
  wire [7:0] misc_mask = {~tlock_r[7], ~tlock_r[6], 6'h3F};
  wire [7:0] misc_new = (misc_r & ~misc_mask) | (i_io_wdata & misc_mask);

  // ----------------------------------------
  // Index and extension registers
  // ----------------------------------------
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      gfx_idx_r <= `VXL_RST_BYTE;
      seq_idx_r <= `VXL_RST_BYTE;
      crt_idx_r <= `VXL_RST_BYTE;
      vid_sel_r <= `VXL_RST_BYTE;
      tlock_r <= `VXL_RST_BYTE;
      mb_win_r <= `VXL_RST_BYTE;
      ext_ctl_r <= `VXL_RST_BYTE;
      cw_ctl_r <= `VXL_RST_BYTE;
      misc_r <= `VXL_RST_BYTE;
    end
    else
    begin
      if (i_io_wr && i_io_addr == `VXL_PORT_GFX_IDX)
        gfx_idx_r <= i_io_wdata;
      if (i_io_wr && i_io_addr == `VXL_PORT_SEQ_IDX)
        seq_idx_r <= i_io_wdata;
      if (i_io_wr && crt_idx_port)
        crt_idx_r <= i_io_wdata;
      if (gfx_dat_wr && gfx_idx_r == `VXL_IDX_VID_SEL)
        vid_sel_r <= i_io_wdata;
      if (gfx_dat_wr && gfx_idx_r == `VXL_IDX_TLOCK)
        tlock_r <= i_io_wdata;
      if (seq_dat_wr && seq_idx_r == `VXL_IDX_MB_WIN)
        mb_win_r <= {4'h0, i_io_wdata[3:0]};
      if (seq_dat_wr && seq_idx_r == `VXL_IDX_EXT_CTL)
        ext_ctl_r <= i_io_wdata;
      if (seq_dat_wr && seq_idx_r == `VXL_IDX_CW_CTL)
        cw_ctl_r <= i_io_wdata;
      if (i_io_wr && i_io_addr == `VXL_PORT_MISC_WR)
        misc_r <= misc_new;
    end
  end

  // ----------------------------------------
  // Memory interface control with strap load
  // ----------------------------------------
  // Strap is sampled after release, so reset itself only loads constants
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      strap_s1_r <= 1'b0;
      strap_s2_r <= 1'b0;
      strap_v1_r <= 1'b0;
      strap_v2_r <= 1'b0;
      strap_done_r <= 1'b0;
      mem_if_r <= `VXL_RST_BYTE;
    end
    else
    begin
      strap_s1_r <= i_strap_bit0;
      strap_s2_r <= strap_s1_r;
      // Load waits until the second sync stage holds the pin level
      strap_v1_r <= 1'b1;
      strap_v2_r <= strap_v1_r;
      strap_done_r <= strap_v2_r;
      if (strap_v2_r && !strap_done_r)
        mem_if_r[`VXL_MIF_ROM_OUT] <= ~strap_s2_r;
      else if (gfx_dat_wr && gfx_idx_r == `VXL_IDX_MEM_IF)
        mem_if_r <= {i_io_wdata[7:2], 1'b0, i_io_wdata[0]};
    end
  end

  // ----------------------------------------
  // CRTC register file
  // ----------------------------------------
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      for (int k = 0; k < CRT_REGS; k++)
        crt_r[k] <= `VXL_RST_BYTE;
    end
    else if (crt_dat_wr)
      crt_r[crt_idx_r[4:0]] <= crt_new;
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  logic [7:0] rd_nxt;
  always_comb
  begin
    rd_nxt = 8'h00;
    if (i_io_addr == `VXL_PORT_GFX_IDX)
      rd_nxt = gfx_idx_r;
    else if (i_io_addr == `VXL_PORT_SEQ_IDX)
      rd_nxt = seq_idx_r;
    else if (crt_idx_port)
      rd_nxt = crt_idx_r;
    else if (i_io_addr == `VXL_PORT_MISC_RD)
      rd_nxt = misc_r;
    else if (i_io_addr == `VXL_PORT_GFX_DAT && gfx_idx_r == `VXL_IDX_MEM_IF)
      rd_nxt = mem_if_r;
    else if (i_io_addr == `VXL_PORT_GFX_DAT && gfx_idx_r == `VXL_IDX_VID_SEL)
      rd_nxt = vid_sel_r;
    else if (i_io_addr == `VXL_PORT_GFX_DAT && gfx_idx_r == `VXL_IDX_TLOCK)
      rd_nxt = tlock_r;
    else if (i_io_addr == `VXL_PORT_SEQ_DAT && seq_idx_r == `VXL_IDX_MB_WIN)
      rd_nxt = mb_win_r;
    else if (i_io_addr == `VXL_PORT_SEQ_DAT && seq_idx_r == `VXL_IDX_EXT_CTL)
      rd_nxt = ext_ctl_r;
    else if (i_io_addr == `VXL_PORT_SEQ_DAT && seq_idx_r == `VXL_IDX_CW_CTL)
      rd_nxt = cw_ctl_r;
    else if (crt_dat_port && crt_idx_r <= `VXL_IDX_CRT_LAST)
      rd_nxt = crt_cur;
  end

  // ----------------------------------------
  // Decode of memory window and display functions
  // ----------------------------------------
  vxl_pkg::vxl_map_t map_sel;
  assign map_sel = vxl_pkg::vxl_map_t'(mem_if_r[5:4]);
  wire in_mb = i_mem_addr[23:20] == mb_win_r[3:0];
  logic hit_nxt;
  always_comb
  begin
    hit_nxt = 1'b0;
    case (map_sel)
      vxl_pkg::VXL_MAP_VGA: hit_nxt = i_mem_addr[23:17] == 7'h05;
      vxl_pkg::VXL_MAP_256K: hit_nxt = in_mb && i_mem_addr[19:18] == 2'b00;
      vxl_pkg::VXL_MAP_512K: hit_nxt = in_mb && !i_mem_addr[19];
      default: hit_nxt = in_mb;
    endcase
  end
  wire cycle_hit = hit_nxt & i_mem_cycle;

  wire [1:0] map_bits = {vid_sel_r[5], vid_sel_r[2]};
  wire plane3_nxt = map_bits == 2'b10 || (map_bits == 2'b11 && i_attr_code[3]);
  logic [3:0] dots_nxt;
  always_comb
  begin
    dots_nxt = 4'd8;
    if (i_graphics_mode)
      dots_nxt = 4'd8;
    else if (vid_sel_r[4:3] == 2'b00)
      dots_nxt = i_nine_dot ? 4'd9 : 4'd8;
    else if (vid_sel_r[4:3] == 2'b01)
      dots_nxt = 4'd7;
    else if (vid_sel_r[4:3] == 2'b10)
      dots_nxt = 4'd9;
    else
      dots_nxt = cw_ctl_r[`VXL_CW_TEN] ? 4'd10 : 4'd8;
  end

  // Doubling shifts in a low zero bit; five-bit fields become six-bit counts
  function automatic logic [5:0] dbl(input logic [4:0] v, input logic en);
    return en ? {v, 1'b0} : {1'b0, v};
  endfunction

  // ----------------------------------------
  // Output flops
  // ----------------------------------------
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_io_rdata <= 8'h00;
      o_mem_hit <= 1'b0;
      o_memcs16_n <= 1'b1;
      o_rom_unmap <= 1'b0;
      o_alt_offset_en <= 1'b0;
      o_legacy_crt <= 1'b0;
      o_char_plane3 <= 1'b0;
      o_page_mode <= 1'b0;
      o_char_dots <= 4'd8;
      o_underline <= 1'b0;
      o_attr_eff <= 8'h00;
      o_hclk_half <= 1'b0;
      o_sync_pol <= 2'b00;
      o_start_addr <= 18'h0_0000;
      o_cursor_addr <= 18'h0_0000;
      o_cursor_start <= 6'h00;
      o_cursor_stop <= 6'h00;
      o_preset_row <= 6'h00;
      o_max_scan <= 6'h00;
      o_group_locked <= 5'h00;
    end
    else
    begin
      if (i_io_rd)
        o_io_rdata <= rd_nxt;
      o_mem_hit <= cycle_hit;
      o_memcs16_n <= ~(cycle_hit & mem_if_r[`VXL_MIF_CS16]);
      o_rom_unmap <= mem_if_r[`VXL_MIF_ROM_OUT];
      o_alt_offset_en <= mem_if_r[`VXL_MIF_ALT_OFS];
      o_legacy_crt <= vid_sel_r[6];
      o_page_mode <= ext_ctl_r[`VXL_EXT_PAGE];
      o_char_plane3 <= ext_ctl_r[`VXL_EXT_PAGE] ? 1'b0 : plane3_nxt;
      o_char_dots <= dots_nxt;
      o_underline <= vid_sel_r[2] & i_attr_code[0];
      o_attr_eff <= vid_sel_r[2] ? (i_attr_code & 8'hF7) : i_attr_code;
      o_hclk_half <= i_seq_half_clk & ~vid_sel_r[0];
      o_sync_pol <= misc_r[7:6];
      o_start_addr <= {tlock_r[4:3], crt_r[12], crt_r[13]};
      o_cursor_addr <= {tlock_r[4:3], crt_r[14], crt_r[15]};
      o_cursor_start <= dbl(crt_r[10][4:0], tlock_r[2]);
      o_cursor_stop <= dbl(crt_r[11][4:0], tlock_r[2]);
      o_preset_row <= dbl(crt_r[8][4:0], tlock_r[2]);
      o_max_scan <= dbl(crt_r[9][4:0], tlock_r[2]);
      o_group_locked <= {lk_g4, lk_g3, lk_g2, lk_g1, lk_g0};
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_CS16: assert property (@(posedge i_clk) disable iff (i_rst)
    cycle_hit && mem_if_r[2] |=> !o_memcs16_n)
    else $error("chip select not asserted");
  AST_MISC_LOCK: assert property (@(posedge i_clk) disable iff (i_rst)
    tlock_r[7] |=> misc_r[7] == $past(misc_r[7]))
    else $error("vsync polarity changed while locked");
  AST_G0_LOCK: assert property (@(posedge i_clk) disable iff (i_rst)
    (tlock_r[5] || prot) && crt_idx_r == 8'h00 |=> crt_r[0] == $past(crt_r[0]))
    else $error("group zero written while locked");
  AST_G1_OPEN: assert property (@(posedge i_clk) disable iff (i_rst)
    crt_dat_wr && crt_idx_r == 8'h07 && tlock_r[1] |=> crt_r[7][6] == $past(i_io_wdata[6]))
    else $error("group one blocked despite prevention");
  AST_G3_LOCK: assert property (@(posedge i_clk) disable iff (i_rst)
    tlock_r[0] && crt_idx_r == 8'h10 |=> $stable(crt_r[16]))
    else $error("group three written while locked");
  AST_G4_LOCK: assert property (@(posedge i_clk) disable iff (i_rst)
    tlock_r[5] |=> crt_r[23][2] == $past(crt_r[23][2]))
    else $error("group four written while locked");
  AST_PLANE: assert property (@(posedge i_clk) disable iff (i_rst)
    ext_ctl_r[2] |=> !o_char_plane3)
    else $error("page mode did not override plane");
  AST_DOTS: assert property (@(posedge i_clk) disable iff (i_rst)
    i_graphics_mode |=> o_char_dots == 4'd8)
    else $error("graphics width not eight");
  AST_START_HI: assert property (@(posedge i_clk) disable iff (i_rst)
    1'b1 |=> o_start_addr[17:16] == $past(tlock_r[4:3]))
    else $error("start address high bits wrong");
  AST_UNDER: assert property (@(posedge i_clk) disable iff (i_rst)
    vid_sel_r[2] |=> !o_attr_eff[3] && o_underline == $past(i_attr_code[0]))
    else $error("underline or background bit wrong");

endmodule
`default_nettype wire

// ===== dv/vxl_host.sv
// Host processor model: issues one-cycle I/O write and read strobes.
// Assumes the bank answers reads on the edge that samples the strobe.
`default_nettype none
module vxl_host (
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  output logic [15:0] o_addr,
  output logic o_wr,
  output logic o_rd,
  output logic [7:0] o_wdata
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    o_addr = 16'h0000;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_wdata = 8'h00;
  end
  // Released bus shows inverted values so stale data never looks valid
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_clk);
    #1;
    o_addr = a;
    o_wdata = d;
    o_wr = 1'b1;
    @(posedge i_clk);
    #1;
    o_wr = 1'b0;
    o_addr = ~a;
    o_wdata = ~d;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge i_clk);
    #1;
    o_addr = a;
    o_rd = 1'b1;
    @(posedge i_clk);
    #1;
    o_rd = 1'b0;
    o_addr = ~a;
    d = i_rdata;
  endtask
endmodule
`default_nettype wire

// ===== dv/tb.sv
// Self-checking bench for the extension register bank.
// Assumes the host model drives all I/O strobes.
`include "vxl_params.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_clk, i_rst, i_io_wr, i_io_rd, i_mem_cycle, i_strap_bit0;
  logic i_graphics_mode, i_nine_dot, i_seq_half_clk;
  logic [15:0] i_io_addr;
  logic [7:0] i_io_wdata, o_io_rdata, i_attr_code, o_attr_eff, rv;
  logic [23:0] i_mem_addr;
  logic o_mem_hit, o_memcs16_n, o_rom_unmap, o_alt_offset_en, o_legacy_crt, o_char_plane3;
  logic o_page_mode, o_underline, o_hclk_half;
  logic [3:0] o_char_dots;
  logic [1:0] o_sync_pol;
  logic [17:0] o_start_addr, o_cursor_addr;
  logic [5:0] o_cursor_start, o_cursor_stop, o_preset_row, o_max_scan;
  logic [4:0] o_group_locked;
  int err_count = 0;
  int n_compared = 0;
  vxl_regs dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_io_addr(i_io_addr), .i_io_wr(i_io_wr),
    .i_io_rd(i_io_rd), .i_io_wdata(i_io_wdata), .o_io_rdata(o_io_rdata),
    .i_mem_addr(i_mem_addr), .i_mem_cycle(i_mem_cycle), .i_strap_bit0(i_strap_bit0),
    .i_attr_code(i_attr_code), .i_graphics_mode(i_graphics_mode), .i_nine_dot(i_nine_dot),
    .i_seq_half_clk(i_seq_half_clk), .o_mem_hit(o_mem_hit), .o_memcs16_n(o_memcs16_n),
    .o_rom_unmap(o_rom_unmap), .o_alt_offset_en(o_alt_offset_en),
    .o_legacy_crt(o_legacy_crt), .o_char_plane3(o_char_plane3), .o_page_mode(o_page_mode),
    .o_char_dots(o_char_dots), .o_underline(o_underline), .o_attr_eff(o_attr_eff),
    .o_hclk_half(o_hclk_half), .o_sync_pol(o_sync_pol), .o_start_addr(o_start_addr),
    .o_cursor_addr(o_cursor_addr), .o_cursor_start(o_cursor_start),
    .o_cursor_stop(o_cursor_stop), .o_preset_row(o_preset_row), .o_max_scan(o_max_scan),
    .o_group_locked(o_group_locked));
  vxl_host host_u (.i_clk(i_clk), .i_rdata(o_io_rdata), .o_addr(i_io_addr), .o_wr(i_io_wr),
    .o_rd(i_io_rd), .o_wdata(i_io_wdata));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  initial
  begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic settle();
    repeat (2) @(posedge i_clk);
    #1;
  endtask
  task automatic ext(input logic [7:0] idx, input logic [7:0] d);
    host_u.wr(`VXL_PORT_GFX_IDX, idx);
    host_u.wr(`VXL_PORT_GFX_DAT, d);
    settle();
  endtask
  task automatic seqw(input logic [7:0] idx, input logic [7:0] d);
    host_u.wr(`VXL_PORT_SEQ_IDX, idx);
    host_u.wr(`VXL_PORT_SEQ_DAT, d);
  endtask
  task automatic crt(input logic [7:0] idx, input logic [7:0] d);
    host_u.wr(`VXL_PORT_CRT_IDX_C, idx);
    host_u.wr(`VXL_PORT_CRT_DAT_C, d);
    settle();
  endtask
  task automatic crt_rd(input logic [7:0] idx, output logic [7:0] d);
    host_u.wr(`VXL_PORT_CRT_IDX_C, idx);
    host_u.rd(`VXL_PORT_CRT_DAT_C, d);
  endtask
  task automatic mem(input logic [23:0] a, input logic hit, input logic cs_n);
    i_mem_addr = a;
    i_mem_cycle = 1'b1;
    settle();
    chk(o_mem_hit, hit);
    chk(o_memcs16_n, cs_n);
    i_mem_cycle = 1'b0;
    i_mem_addr = ~a;
    @(posedge i_clk);
    #1;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk(o_rom_unmap, 1'b1);
    chk(o_memcs16_n, 1'b1);
    chk(o_char_dots, 4'h8);
    chk(o_group_locked, 5'h00);
  endtask
  // Mid-run reset with the strap pulled high: the ROM stays mapped
  task automatic t_strap();
    i_strap_bit0 = 1'b1;
    i_rst = 1'b1;
    repeat (3) @(posedge i_clk);
    #1;
    chk(o_memcs16_n, 1'b1);
    i_rst = 1'b0;
    repeat (4) @(posedge i_clk);
    #1;
    chk(o_rom_unmap, 1'b0);
    chk(o_group_locked, 5'h00);
    i_strap_bit0 = 1'b0;
  endtask
  task automatic t_memory();
    ext(`VXL_IDX_MEM_IF, 8'h0D);
    chk(o_rom_unmap, 1'b1);
    chk(o_alt_offset_en, 1'b1);
    mem(24'h0A_0000, 1'b1, 1'b0);
    mem(24'h0B_FFFF, 1'b1, 1'b0);
    mem(24'h0C_0000, 1'b0, 1'b1);
    seqw(`VXL_IDX_MB_WIN, 8'h02);
    ext(`VXL_IDX_MEM_IF, 8'h14);
    chk(o_rom_unmap, 1'b0);
    chk(o_alt_offset_en, 1'b0);
    mem(24'h23_FFFF, 1'b1, 1'b0);
    mem(24'h24_0000, 1'b0, 1'b1);
    mem(24'h13_FFFF, 1'b0, 1'b1);
    ext(`VXL_IDX_MEM_IF, 8'h24);
    mem(24'h27_FFFF, 1'b1, 1'b0);
    mem(24'h28_0000, 1'b0, 1'b1);
    ext(`VXL_IDX_MEM_IF, 8'h30);
    mem(24'h2F_FFFF, 1'b1, 1'b1);
  endtask
  task automatic t_video();
    logic [3:0] dots [4];
    dots = '{4'h9, 4'h7, 4'h9, 4'h8};
    i_nine_dot = 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      ext(`VXL_IDX_VID_SEL, 8'(k << 3));
      chk(o_char_dots, dots[k]);
    end
    seqw(`VXL_IDX_CW_CTL, 8'h20);
    settle();
    chk(o_char_dots, 4'hA);
    i_graphics_mode = 1'b1;
    settle();
    chk(o_char_dots, 4'h8);
    i_graphics_mode = 1'b0;
    i_attr_code = 8'h09;
    i_seq_half_clk = 1'b1;
    ext(`VXL_IDX_VID_SEL, 8'h45);
    chk(o_legacy_crt, 1'b1);
    chk(o_underline, 1'b1);
    chk(o_attr_eff, 8'h01);
    chk(o_hclk_half, 1'b0);
    chk(o_char_plane3, 1'b0);
    ext(`VXL_IDX_VID_SEL, 8'h20);
    chk(o_hclk_half, 1'b1);
    chk(o_attr_eff, 8'h09);
    chk(o_char_plane3, 1'b1);
    ext(`VXL_IDX_VID_SEL, 8'h24);
    chk(o_char_plane3, 1'b1);
    i_attr_code = 8'h01;
    settle();
    chk(o_char_plane3, 1'b0);
    i_attr_code = 8'h09;
    seqw(`VXL_IDX_EXT_CTL, 8'h04);
    settle();
    chk(o_page_mode, 1'b1);
    chk(o_char_plane3, 1'b0);
  endtask
  task automatic t_sync_lock();
    host_u.wr(`VXL_PORT_MISC_WR, 8'hC0);
    ext(`VXL_IDX_TLOCK, 8'hC0);
    host_u.wr(`VXL_PORT_MISC_WR, 8'h00);
    settle();
    chk(o_sync_pol, 2'b11);
    ext(`VXL_IDX_TLOCK, 8'h00);
    host_u.wr(`VXL_PORT_MISC_WR, 8'h40);
    settle();
    chk(o_sync_pol, 2'b01);
    ext(`VXL_IDX_TLOCK, 8'h40);
    host_u.wr(`VXL_PORT_MISC_WR, 8'h80);
    settle();
    chk(o_sync_pol, 2'b11);
    host_u.rd(`VXL_PORT_MISC_RD, rv);
    chk(rv, 8'hC0);
    ext(`VXL_IDX_TLOCK, 8'h00);
  endtask
  task automatic t_addr_scan();
    ext(`VXL_IDX_TLOCK, 8'h1C);
    crt(8'h0C, 8'h12);
    crt(8'h0D, 8'h34);
    crt(8'h0E, 8'h56);
    crt(8'h0F, 8'h78);
    crt(8'h0A, 8'h05);
    crt(8'h09, 8'h1F);
    crt(8'h08, 8'h11);
    host_u.wr(`VXL_PORT_CRT_IDX_M, 8'h0B);
    host_u.wr(`VXL_PORT_CRT_DAT_M, 8'h03);
    settle();
    chk(o_start_addr, 18'h3_1234);
    chk(o_cursor_addr, 18'h3_5678);
    chk(o_cursor_start, 6'h0A);
    chk(o_max_scan, 6'h3E);
    chk(o_preset_row, 6'h22);
    chk(o_cursor_stop, 6'h06);
    ext(`VXL_IDX_TLOCK, 8'h00);
    chk(o_cursor_start, 6'h05);
  endtask
  task automatic t_locks();
    ext(`VXL_IDX_TLOCK, 8'h20);
    host_u.rd(`VXL_PORT_GFX_DAT, rv);
    chk(rv, 8'h20);
    chk(o_group_locked, 5'b10001);
    crt(8'h00, 8'h55);
    crt(8'h17, 8'h04);
    crt(8'h11, 8'h00);
    chk(o_group_locked, 5'b10001);
    crt_rd(8'h00, rv);
    chk(rv, 8'h00);
    crt_rd(8'h17, rv);
    chk(rv, 8'h00);
    ext(`VXL_IDX_TLOCK, 8'h00);
    crt(8'h00, 8'h55);
    crt_rd(8'h00, rv);
    chk(rv, 8'h55);
    crt(8'h11, 8'h80);
    chk(o_group_locked, 5'b00111);
    crt(8'h00, 8'hAA);
    crt(8'h07, 8'hFF);
    crt_rd(8'h00, rv);
    chk(rv, 8'h55);
    crt_rd(8'h07, rv);
    chk(rv, 8'h10);
    ext(`VXL_IDX_TLOCK, 8'h02);
    chk(o_group_locked, 5'b00101);
    crt(8'h07, 8'hFF);
    crt_rd(8'h07, rv);
    chk(rv, 8'h52);
    ext(`VXL_IDX_TLOCK, 8'h01);
    crt(8'h11, 8'h0F);
    chk(o_group_locked, 5'b01100);
    crt(8'h10, 8'h77);
    crt(8'h06, 8'h66);
    crt_rd(8'h10, rv);
    chk(rv, 8'h00);
    crt_rd(8'h06, rv);
    chk(rv, 8'h00);
    crt_rd(8'h11, rv);
    chk(rv, 8'h00);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  task automatic report_and_stop();
    if (err_count == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    i_rst = 1'b1;
    i_mem_addr = 24'h00_0000;
    i_mem_cycle = 1'b0;
    i_strap_bit0 = 1'b0;
    i_attr_code = 8'h00;
    i_graphics_mode = 1'b0;
    i_nine_dot = 1'b0;
    i_seq_half_clk = 1'b0;
    repeat (10) @(posedge i_clk);
    #1;
    i_rst = 1'b0;
    repeat (4) @(posedge i_clk);
    #1;
    t_reset();
    t_strap();
    t_memory();
    t_video();
    t_sync_lock();
    t_addr_scan();
    t_locks();
    report_and_stop();
  end
  initial
  begin
    #50000;
    err_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire
